// ### rtl/iss_top.sv
// interrupt input gating and source selection with ahb-lite registers
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ns
module iss_top #(
	parameter int KEY_WIDTH = 8
) (
	// clock and reset
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// ahb-lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// raw pins, levels
	input  wire logic                 ext_irq_pin_five,
	input  wire logic                 ext_irq_pin_six,
	input  wire logic                 ext_irq_pin_seven,
	input  wire logic [KEY_WIDTH-1:0] key_in,
	input  wire logic                 nmi_in,
	// peripheral events, one-cycle pulses
	input  wire logic                 i2c_ev,
	input  wire logic                 scl_sda_ev,
	input  wire logic                 serial_port_eight_ss_ev,
	input  wire logic                 serial_port_eight_tx_ev,
	input  wire logic                 remote_rx0_ev,
	input  wire logic                 remote_rx1_ev,
	input  wire logic                 timer_b_three_ev,
	input  wire logic                 timer_b_four_ev,
	input  wire logic                 serial_port_first_ss_ev,
	input  wire logic                 serial_port_second_ss_ev,
	// towards cpu interrupt logic
	output logic                      ext5_req,
	output logic                      ext6_lvl,
	output logic                      ext7_lvl,
	output logic      [KEY_WIDTH-1:0] key_lvl,
	output logic                      nmi_lvl,
	output logic                      i2c_req,
	output logic                      scl_sda_req,
	output logic                      slot_a_req,
	output logic                      slot_b_req,
	output logic                      slot_c_req,
	output logic                      slot_d_req,
	output logic                      irq
);

	// refuse key widths the gating cannot serve
	if (KEY_WIDTH < 1 || KEY_WIDTH > 32) begin : g_chk
		$error("iss_top: KEY_WIDTH must be 1 to 32");
	end

	// refuse field positions that do not fit in an eight-bit register
	if (iss_pkg::PORT_CTL_KEY_DIS > 7 || iss_pkg::MODE_TWO_NMI_EN > 7
		|| iss_pkg::SS2_SS1 > 7 || iss_pkg::SS1_BOTH_EDGE > 7) begin : g_chk_fields
		$error("iss_top: a control field lies outside its register");
	end

	// every piece of state, registered as one word
	typedef struct packed {
		// documented control registers
		logic [7:0]           port_ctl;
		logic [7:0]           mode_two;
		logic [7:0]           ss3;
		logic [7:0]           ss2;
		logic [7:0]           ss1;
		// address-match registers, stored only
		logic [7:0]           ame;
		logic [7:0]           ame2;
		logic [3:0][23:0]     amv;
		// sticky status and its enable
		logic [7:0]           stat;
		logic [7:0]           en;
		// bus pipeline: pending write and read data
		logic                 wr_pend;
		logic [11:0]          wr_idx;
		logic [31:0]          rdata;
		// edge history
		logic                 ext5_prev;
		logic                 nmi_prev;
		// registered outputs towards the cpu
		logic                 ext5_req;
		logic                 ext6_lvl;
		logic                 ext7_lvl;
		logic [KEY_WIDTH-1:0] key_lvl;
		logic                 nmi_lvl;
		logic                 i2c_req;
		logic                 scl_sda_req;
		logic                 slot_a_req;
		logic                 slot_b_req;
		logic                 slot_c_req;
		logic                 slot_d_req;
	} iss_state_t;

	iss_state_t st_r;
	iss_state_t st_nxt;

	// read value of one register index from a state copy
	function automatic logic [31:0] iss_read(input iss_state_t s, input logic [11:0] idx);
		logic [31:0] v;
		v = iss_pkg::RD_ZERO;
		unique case (idx)
			// one-byte control registers
			iss_pkg::IDX_MODE_TWO: begin
				v[7:0] = s.mode_two;
			end
			iss_pkg::IDX_SS3: begin
				v[7:0] = s.ss3;
			end
			iss_pkg::IDX_SS2: begin
				v[7:0] = s.ss2;
			end
			iss_pkg::IDX_SS1: begin
				v[7:0] = s.ss1;
			end
			iss_pkg::IDX_AME: begin
				v[7:0] = s.ame;
			end
			iss_pkg::IDX_AME2: begin
				v[7:0] = s.ame2;
			end
			iss_pkg::IDX_PORT_CTL: begin
				v[7:0] = s.port_ctl;
			end
			// address-match values, 24 bits each
			iss_pkg::IDX_AMV0: begin
				v[23:0] = s.amv[0];
			end
			iss_pkg::IDX_AMV1: begin
				v[23:0] = s.amv[1];
			end
			iss_pkg::IDX_AMV2: begin
				v[23:0] = s.amv[2];
			end
			iss_pkg::IDX_AMV3: begin
				v[23:0] = s.amv[3];
			end
			// status and enable; the clear register reads as zero
			iss_pkg::IDX_STAT: begin
				v[7:0] = s.stat;
			end
			iss_pkg::IDX_EN: begin
				v[7:0] = s.en;
			end
			default:           v = iss_pkg::RD_ZERO;
		endcase
		return v;
	endfunction : iss_read

	// apply one data-phase write to a state copy
	function automatic iss_state_t iss_write(input iss_state_t s, input logic [11:0] idx,
		input logic [31:0] d);
		iss_state_t n;
		n = s;
		unique case (idx)
			// one-byte control registers
			iss_pkg::IDX_MODE_TWO: begin
				n.mode_two = d[7:0];
			end
			iss_pkg::IDX_SS3: begin
				n.ss3 = d[7:0];
			end
			iss_pkg::IDX_SS2: begin
				n.ss2 = d[7:0];
			end
			iss_pkg::IDX_SS1: begin
				n.ss1 = d[7:0];
			end
			iss_pkg::IDX_AME: begin
				n.ame = d[7:0];
			end
			iss_pkg::IDX_AME2: begin
				n.ame2 = d[7:0];
			end
			iss_pkg::IDX_PORT_CTL: begin
				n.port_ctl = d[7:0];
			end
			// address-match values keep their low 24 bits
			iss_pkg::IDX_AMV0: begin
				n.amv[0] = d[23:0];
			end
			iss_pkg::IDX_AMV1: begin
				n.amv[1] = d[23:0];
			end
			iss_pkg::IDX_AMV2: begin
				n.amv[2] = d[23:0];
			end
			iss_pkg::IDX_AMV3: begin
				n.amv[3] = d[23:0];
			end
			// clear takes write-one-to-clear; enable is stored as written
			iss_pkg::IDX_CLR: begin
				n.stat = s.stat & ~d[7:0];
			end
			iss_pkg::IDX_EN: begin
				n.en = d[7:0];
			end
			default:           n = s;  // status and unmapped indices ignore writes
		endcase
		return n;
	endfunction : iss_write

	// edge test used by the pin-five detector and the nmi status
	function automatic logic iss_edge(input logic prev, input logic cur, input logic rise);
		return rise ? (cur & ~prev) : (prev & ~cur);
	endfunction : iss_edge

	// level gate: pass the input only while the enable is high
	function automatic logic iss_gate(input logic lvl, input logic enable);
		return lvl & enable;
	endfunction : iss_gate

	// shared-slot selector: only the chosen source can reach the slot,
	// the other source is dropped entirely rather than queued
	function automatic logic iss_pick(input logic sel, input logic when_one,
		input logic when_zero);
		logic r;
		if (sel) begin
			r = when_one;
		end else begin
			r = when_zero;
		end
		return r;
	endfunction : iss_pick

	logic [7:0] ev_vec;
	logic       acc;

	// next-state logic: register writes, gating, routing, status
	always_comb begin
		st_nxt = st_r;
		acc = hsel & hready & (htrans == iss_pkg::HTRANS_NONSEQ);
		ev_vec = 8'h00;

		// data phase of a write lands here, one cycle after its address phase;
		// the address phase of the next transfer may overlap it
		if (st_r.wr_pend) begin
			st_nxt = iss_write(st_r, st_r.wr_idx, hwdata);
		end

		// address phase: latch write target; read data is zero unless a read is taken
		st_nxt.wr_pend = acc & hwrite;
		st_nxt.wr_idx = haddr[13:2];
		st_nxt.rdata = iss_pkg::RD_ZERO;

		// pin gating uses the registers as they stand this cycle, so a write
		// to port control reaches the pins one edge after it lands
		st_nxt.ext6_lvl = iss_gate(ext_irq_pin_six,
			~st_r.port_ctl[iss_pkg::PORT_CTL_SIX_DIS]);                   // R1
		st_nxt.ext7_lvl = iss_gate(ext_irq_pin_seven,
			~st_r.port_ctl[iss_pkg::PORT_CTL_SEVEN_DIS]);                 // R2
		// keys pass bit by bit; detection is left to the cpu side
		if (st_r.port_ctl[iss_pkg::PORT_CTL_KEY_DIS]) begin
			st_nxt.key_lvl = '0;                                          // R3
		end else begin
			st_nxt.key_lvl = key_in;                                      // R3
		end

		// nmi suppressed until software sets the enable in mode register two
		st_nxt.nmi_lvl = iss_gate(nmi_in, st_r.mode_two[iss_pkg::MODE_TWO_NMI_EN]); // R4

		// pin five: falling edge in single-edge mode, any change in both-edge mode;
		// history resets low, so an idle-low pin gives no false edge
		st_nxt.ext5_prev = ext_irq_pin_five;
		if (st_r.ss1[iss_pkg::SS1_BOTH_EDGE]) begin
			st_nxt.ext5_req = ext_irq_pin_five ^ st_r.ext5_prev;          // R10
		end else begin
			st_nxt.ext5_req = iss_edge(st_r.ext5_prev, ext_irq_pin_five, 1'b0); // R10
		end

		// dedicated slots connected only when their select bit is set
		st_nxt.i2c_req = iss_gate(i2c_ev, st_r.ss2[iss_pkg::SS2_I2C]);               // R5
		st_nxt.scl_sda_req = iss_gate(scl_sda_ev, st_r.ss2[iss_pkg::SS2_SCLSDA]);    // R5

		// shared slots: only the selected source reaches the slot;
		// a select change only steers events sampled after it lands
		st_nxt.slot_a_req = iss_pick(st_r.ss2[iss_pkg::SS2_RC0],
			remote_rx0_ev, serial_port_eight_ss_ev);                      // R6 R11
		st_nxt.slot_b_req = iss_pick(st_r.ss2[iss_pkg::SS2_RC1],
			remote_rx1_ev, serial_port_eight_tx_ev);                      // R7 R11
		st_nxt.slot_c_req = iss_pick(st_r.ss2[iss_pkg::SS2_SS0],
			serial_port_first_ss_ev, timer_b_three_ev);                   // R8 R11
		st_nxt.slot_d_req = iss_pick(st_r.ss2[iss_pkg::SS2_SS1],
			serial_port_second_ss_ev, timer_b_four_ev);                   // R9 R11

		// sticky status from routed events; set wins over a clear because
		// the events are merged after the write has been applied
		st_nxt.nmi_prev = st_r.nmi_lvl;
		ev_vec[iss_pkg::ST_EXT5] = st_r.ext5_req;
		ev_vec[iss_pkg::ST_NMI] = iss_edge(st_r.nmi_prev, st_r.nmi_lvl, 1'b1);
		ev_vec[iss_pkg::ST_I2C] = st_r.i2c_req;
		ev_vec[iss_pkg::ST_SCLSDA] = st_r.scl_sda_req;
		ev_vec[iss_pkg::ST_SLOTA] = st_r.slot_a_req;
		ev_vec[iss_pkg::ST_SLOTB] = st_r.slot_b_req;
		ev_vec[iss_pkg::ST_SLOTC] = st_r.slot_c_req;
		ev_vec[iss_pkg::ST_SLOTD] = st_r.slot_d_req;
		st_nxt.stat = st_nxt.stat | ev_vec;

		// read sees any write finishing this cycle, so a read right
		// after a write to the same register returns the new value
		if (acc && !hwrite) begin
			st_nxt.rdata = iss_read(st_nxt, haddr[13:2]);
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// bus answer: zero-wait, always okay
	assign hrdata      = st_r.rdata;
	assign hreadyout   = 1'b1;                // zero-wait slave
	assign hresp       = iss_pkg::HRESP_OKAY;

	// gated and routed requests, straight from flip-flops
	assign ext5_req    = st_r.ext5_req;
	assign ext6_lvl    = st_r.ext6_lvl;
	assign ext7_lvl    = st_r.ext7_lvl;
	assign key_lvl     = st_r.key_lvl;
	assign nmi_lvl     = st_r.nmi_lvl;
	assign i2c_req     = st_r.i2c_req;
	assign scl_sda_req = st_r.scl_sda_req;
	assign slot_a_req  = st_r.slot_a_req;
	assign slot_b_req  = st_r.slot_b_req;
	assign slot_c_req  = st_r.slot_c_req;
	assign slot_d_req  = st_r.slot_d_req;

	// level interrupt from enabled sticky status
	assign irq         = |(st_r.stat & st_r.en);

endmodule : iss_top

// ### rtl/iss_pkg.sv
// constants shared by the interrupt source select block
// Overview of operation
// R1 - port control bit 5 set blocks the sixth external interrupt pin
// R2 - port control bit 6 set blocks the seventh external interrupt pin
// R3 - port control bit 7 set blocks all key-input interrupt requests
// R4 - non-maskable requests pass only while processor mode two bit 4 is set
// R5 - second select bits 2 and 3 connect the I2C and SCL/SDA slots
// R6 - second select bit 4 picks serial eight start/stop or remote receiver 0
// R7 - second select bit 5 picks serial eight transmit/NACK or remote receiver 1
// R8 - second select bit 6 picks timer b three or serial one start/stop
// R9 - second select bit 7 picks timer b four or serial two start/stop
// R10 - first select bit 5 picks one edge or both edges for pin five
// R11 - unselected sources are ignored; select changes affect later events only
package iss_pkg;

	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_MODE_TWO = 12'h01E;
	localparam logic [11:0] IDX_SS3    = 12'h205;
	localparam logic [11:0] IDX_SS2    = 12'h206;
	localparam logic [11:0] IDX_SS1    = 12'h207;
	localparam logic [11:0] IDX_AME    = 12'h20E;
	localparam logic [11:0] IDX_AME2   = 12'h20F;
	localparam logic [11:0] IDX_AMV0   = 12'h210;
	localparam logic [11:0] IDX_AMV1   = 12'h214;
	localparam logic [11:0] IDX_AMV2   = 12'h218;
	localparam logic [11:0] IDX_AMV3   = 12'h21C;
	localparam logic [11:0] IDX_PORT_CTL = 12'h366;
	localparam logic [11:0] IDX_STAT   = 12'h380;
	localparam logic [11:0] IDX_CLR    = 12'h381;
	localparam logic [11:0] IDX_EN     = 12'h382;

	// field positions
	localparam int PORT_CTL_SIX_DIS   = 5;
	localparam int PORT_CTL_SEVEN_DIS = 6;
	localparam int PORT_CTL_KEY_DIS   = 7;
	localparam int MODE_TWO_NMI_EN    = 4;
	localparam int SS2_I2C       = 2;
	localparam int SS2_SCLSDA    = 3;
	localparam int SS2_RC0       = 4;
	localparam int SS2_RC1       = 5;
	localparam int SS2_SS0       = 6;
	localparam int SS2_SS1       = 7;
	localparam int SS1_BOTH_EDGE = 5;

	// status bit positions
	localparam int ST_EXT5   = 0;
	localparam int ST_NMI    = 1;
	localparam int ST_I2C    = 2;
	localparam int ST_SCLSDA = 3;
	localparam int ST_SLOTA  = 4;
	localparam int ST_SLOTB  = 5;
	localparam int ST_SLOTC  = 6;
	localparam int ST_SLOTD  = 7;

	// reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [23:0] RST_AMV  = 24'h000000;
	localparam logic [31:0] RD_ZERO  = 32'h00000000;

	// ahb encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

endpackage : iss_pkg

// ### verification/iss_monitor.sv
// checker for gating and routing of the interrupt source select block
`timescale 1ns/1ns
module iss_monitor #(parameter int KEY_WIDTH = 8) (
	// bus side
	input wire logic hclk, hresetn, hsel, hwrite, hready,
	input wire logic [31:0] haddr, hwdata,
	input wire logic [1:0] htrans,
	// pins and events
	input wire logic ext_irq_pin_five, ext_irq_pin_six, ext_irq_pin_seven, nmi_in,
	input wire logic [KEY_WIDTH-1:0] key_in, key_lvl,
	input wire logic i2c_ev, scl_sda_ev, remote_rx0_ev, remote_rx1_ev,
	input wire logic serial_port_eight_ss_ev, serial_port_eight_tx_ev,
	input wire logic timer_b_three_ev, timer_b_four_ev,
	input wire logic serial_port_first_ss_ev, serial_port_second_ss_ev,
	// requests
	input wire logic ext5_req, ext6_lvl, ext7_lvl, nmi_lvl, i2c_req, scl_sda_req,
	input wire logic slot_a_req, slot_b_req, slot_c_req, slot_d_req
);
	logic        wr_r;
	logic [11:0] idx_r;
	logic [7:0]  port_ctl_r, mode_two_r, ss2_r, ss1_r;
	logic [5:0]  route;
	// shadow copies of the control registers, written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'h0;
			idx_r <= 12'h000;
			{port_ctl_r, mode_two_r, ss2_r, ss1_r} <= 32'h00000000;
		end else begin
			wr_r <= hsel && hready && hwrite && htrans == iss_pkg::HTRANS_NONSEQ;
			idx_r <= haddr[13:2];
			if (wr_r && idx_r == iss_pkg::IDX_PORT_CTL) port_ctl_r <= hwdata[7:0];
			if (wr_r && idx_r == iss_pkg::IDX_MODE_TWO) mode_two_r <= hwdata[7:0];
			if (wr_r && idx_r == iss_pkg::IDX_SS2) ss2_r <= hwdata[7:0];
			if (wr_r && idx_r == iss_pkg::IDX_SS1) ss1_r <= hwdata[7:0];
		end
	end
	// which event each request output should follow
	assign route = {ss2_r[7] ? serial_port_second_ss_ev : timer_b_four_ev,
		ss2_r[6] ? serial_port_first_ss_ev : timer_b_three_ev,
		ss2_r[5] ? remote_rx1_ev : serial_port_eight_tx_ev,
		ss2_r[4] ? remote_rx0_ev : serial_port_eight_ss_ev,
		ss2_r[3] && scl_sda_ev, ss2_r[2] && i2c_ev};
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence fall5; $fell(ext_irq_pin_five); endsequence
	sequence rise5; $rose(ext_irq_pin_five); endsequence
	chk_pin_six: assert property (ext6_lvl == ($past(ext_irq_pin_six) && !$past(port_ctl_r[5])))
		else $error("pin six gating wrong");
	chk_pin_seven: assert property (ext7_lvl == ($past(ext_irq_pin_seven) && !$past(port_ctl_r[6])))
		else $error("pin seven gating wrong");
	chk_key_gate: assert property (key_lvl == ($past(port_ctl_r[7]) ? '0 : $past(key_in)))
		else $error("key gating wrong");
	chk_nmi_gate: assert property (nmi_lvl == ($past(nmi_in) && $past(mode_two_r[4])))
		else $error("nmi gating wrong");
	chk_bus_route: assert property ({scl_sda_req, i2c_req} == $past(route[1:0]))
		else $error("bus slot request wrong");
	chk_slot_ab: assert property ({slot_b_req, slot_a_req} == $past(route[3:2]))
		else $error("slot a or b request wrong");
	chk_slot_cd: assert property ({slot_d_req, slot_c_req} == $past(route[5:4]))
		else $error("slot c or d request wrong");
	chk_fall_five: assert property (fall5 |=> ext5_req)
		else $error("pin five fall missed");
	chk_rise_five: assert property (rise5 |=> ext5_req == $past(ss1_r[5]))
		else $error("pin five rise wrong");
	chk_quiet_five: assert property ($stable(ext_irq_pin_five) |=> !ext5_req)
		else $error("pin five request without edge");
endmodule : iss_monitor
bind iss_top iss_monitor #(.KEY_WIDTH(KEY_WIDTH)) u_iss_monitor (.*);

// ### verification/iss_partner.sv
// model of the peripheral event sources feeding the block
`timescale 1ns/1ns
module iss_partner (
	input wire logic       hclk,
	input wire logic [9:0] fire,
	output logic     [9:0] ev
);
	initial ev = 10'h000;
	// each requested source raises a single-cycle pulse
	always @(posedge hclk) ev <= fire;
endmodule : iss_partner

// ### verification/test_interrupt_source_select.sv
// self-checking bench for the interrupt source select block
`timescale 1ns/1ns
module test_interrupt_source_select;
	logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic p5 = 1'h0, p6 = 1'h0, p7 = 1'h0, nmi = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [1:0] htrans = 2'h0;
	logic [7:0] key = 8'h00, key_lvl;
	logic [9:0] fire = 10'h000, ev;
	logic [5:0] req;
	logic hreadyout, hresp, ext5_req, ext6_lvl, ext7_lvl, nmi_lvl, irq;
	int fails = 0, num_checks = 0;
	iss_partner u_iss_partner (.hclk(hclk), .fire(fire), .ev(ev));
	iss_top u_iss_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin_five(p5),
		.ext_irq_pin_six(p6), .ext_irq_pin_seven(p7), .key_in(key), .nmi_in(nmi),
		.i2c_ev(ev[0]), .scl_sda_ev(ev[1]), .serial_port_eight_ss_ev(ev[2]),
		.remote_rx0_ev(ev[3]), .serial_port_eight_tx_ev(ev[4]), .remote_rx1_ev(ev[5]),
		.timer_b_three_ev(ev[6]), .serial_port_first_ss_ev(ev[7]), .timer_b_four_ev(ev[8]),
		.serial_port_second_ss_ev(ev[9]), .ext5_req(ext5_req), .ext6_lvl(ext6_lvl),
		.ext7_lvl(ext7_lvl), .key_lvl(key_lvl), .nmi_lvl(nmi_lvl), .i2c_req(req[0]),
		.scl_sda_req(req[1]), .slot_a_req(req[2]), .slot_b_req(req[3]),
		.slot_c_req(req[4]), .slot_d_req(req[5]), .irq(irq));
	// 250 MHz clock
	initial begin
		forever #2 hclk = ~hclk;
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one ahb-lite single transfer, waits on ready in both phases
	task automatic xfer(logic w, logic [11:0] i, logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= {18'h0, i, 2'h0};
		hwrite <= w;
		htrans <= iss_pkg::HTRANS_NONSEQ;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		q = hrdata;
	endtask : xfer
	task automatic rd(logic [11:0] i, logic [31:0] e, string n);
		xfer(1'h0, i, 32'h0);
		chk(n, e, q);
	endtask : rd
	// one source pulse, sampled when its request should stand
	task automatic pulse(int k);
		@(posedge hclk);
		fire <= 10'h001 << k;
		@(posedge hclk);
		fire <= 10'h000;
		@(posedge hclk);
		#1;
	endtask : pulse
	task automatic t_regs;
		rd(iss_pkg::IDX_PORT_CTL, 0, "port control reset");
		rd(iss_pkg::IDX_SS2, 0, "ss2 reset");
		xfer(1'h1, iss_pkg::IDX_AMV0, 32'hFFFFFFFF);
		rd(iss_pkg::IDX_AMV0, 32'h00FFFFFF, "amv0 width");
		xfer(1'h1, 12'h100, 32'hFFFFFFFF);
		rd(12'h100, 0, "unmapped");
		chk("hresp", 0, hresp);
		$display("regs test done");
	endtask : t_regs
	task automatic t_gate;
		p6 <= 1'h1;
		p7 <= 1'h1;
		nmi <= 1'h1;
		key <= 8'hA5;
		for (int b = 0; b < 8; b++) begin
			xfer(1'h1, iss_pkg::IDX_PORT_CTL, b << 5);
			xfer(1'h1, iss_pkg::IDX_MODE_TWO, b[0] << 4);
			rd(iss_pkg::IDX_PORT_CTL, b << 5, "port control readback");
			#1;
			chk("ext6", !b[0], ext6_lvl);
			chk("ext7", !b[1], ext7_lvl);
			chk("key", b[2] ? 0 : 8'hA5, key_lvl);
			chk("nmi", b[0], nmi_lvl);
		end
		$display("gate test done");
	endtask : t_gate
	task automatic t_route;
		for (int s = 0; s < 2; s++) begin
			xfer(1'h1, iss_pkg::IDX_SS2, s ? 32'hFC : 32'h00);
			for (int k = 0; k < 10; k++) begin
				pulse(k);
				chk("req", (s ? (k < 2 || k % 2) : (k > 1 && k % 2 == 0)) << (k < 2 ? k : k / 2 + 1), req);
			end
		end
		$display("route test done");
	endtask : t_route
	task automatic t_irq;
		xfer(1'h1, iss_pkg::IDX_CLR, 32'hFF);
		rd(iss_pkg::IDX_STAT, 0, "status cleared");
		xfer(1'h1, iss_pkg::IDX_SS2, 32'h0);
		xfer(1'h1, iss_pkg::IDX_EN, 32'h40);
		pulse(6);
		@(posedge hclk);
		#1;
		chk("irq raised", 1, irq);
		xfer(1'h1, iss_pkg::IDX_EN, 32'h0);
		#1;
		chk("irq masked", 0, irq);
		rd(iss_pkg::IDX_STAT, 32'h40, "status");
		xfer(1'h1, iss_pkg::IDX_EN, 32'h40);
		xfer(1'h1, iss_pkg::IDX_CLR, 32'h40);
		#1;
		chk("irq cleared", 0, irq);
		$display("irq test done");
	endtask : t_irq
	task automatic edge5(logic v, logic e);
		@(posedge hclk);
		p5 <= v;
		@(posedge hclk);
		#1;
		chk("ext5", e, ext5_req);
	endtask : edge5
	task automatic t_ext5;
		edge5(1'h1, 1'h0);
		edge5(1'h0, 1'h1);
		xfer(1'h1, iss_pkg::IDX_SS1, 32'h20);
		edge5(1'h1, 1'h1);
		edge5(1'h0, 1'h1);
		$display("pin five test done");
	endtask : t_ext5
	task automatic stop_test;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	// watchdog against a hung handshake
	initial begin
		#40000;
		fails++;
		stop_test;
	end
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		t_regs;
		t_gate;
		t_route;
		t_irq;
		t_ext5;
		stop_test;
	end
endmodule : test_interrupt_source_select
